// ==== core/if_counter_pkg.sv ====
// constants shared by the frequency counter modules
package if_counter_pkg;
  // clock and timing
  localparam int MCLK_KHZ       = 25000;
  localparam int TICK_PERIOD_US = 1000;
  localparam int TICK_CYCLES    = TICK_PERIOD_US * MCLK_KHZ / 1000;
  localparam int TICK_W         = 15;

  // register byte addresses
  localparam logic [7:0] FREQ_COUNTER_MODE_REG_ADDR = 8'hF4;
  localparam logic [7:0] FREQ_COUNT_HIGH_REG_ADDR   = 8'hF5;
  localparam logic [7:0] FREQ_COUNT_MID_REG_ADDR    = 8'hF6;
  localparam logic [7:0] FREQ_COUNT_LOW_REG_ADDR    = 8'hF7;

  // mode register fields
  localparam int COUNT_DONE_JUDGE_FLAG_BIT = 7;
  localparam int COUNT_START_STOP_BIT      = 6;
  localparam int COUNT_CLEAR_BIT           = 5;
  localparam int GATE_TIME_SEL_LSB         = 2;
  localparam int INPUT_SEL_ENABLE_BIT      = 1;
  localparam int INPUT_SEL_AM_FM_BIT       = 0;

  // high result register fields
  localparam int         COUNT_OVERFLOW_FLAG_BIT = 3;
  localparam logic [3:0] HIGH_RSVD_VALUE         = 4'hF;

  // gate time codes and lengths in milliseconds
  localparam logic [2:0] GT_8MS   = 3'h0;
  localparam logic [2:0] GT_32MS  = 3'h1;
  localparam logic [2:0] GT_128MS = 3'h2;
  localparam logic [2:0] GT_SOFT  = 3'h3;
  localparam logic [2:0] GT_1MS   = 3'h4;
  localparam logic [2:0] GT_4MS   = 3'h5;
  localparam logic [7:0] LEN_8MS   = 8'h08;
  localparam logic [7:0] LEN_32MS  = 8'h20;
  localparam logic [7:0] LEN_128MS = 8'h80;
  localparam logic [7:0] LEN_1MS   = 8'h01;
  localparam logic [7:0] LEN_4MS   = 8'h04;

  // counter
  localparam int          CNT_W     = 19;
  localparam logic [18:0] OVF_VALUE = 19'h7FFFF;
  localparam logic [18:0] CNT_RESET = 19'h00000;
  localparam logic [7:0]  MODE_RESET = 8'h00;
  localparam logic [7:0]  UNMAPPED_READ = 8'h00;
endpackage

// ==== core/if_sel_intf.sv ====
// carrier between the counter core and its input conditioner
`timescale 1ns/1ps
interface if_sel_intf;
  logic [1:0] inSel;     // input select field
  logic       cntPulse;  // one count to add
  logic       cntLevel;  // level of the counted signal
  modport core (output inSel, input cntPulse, input cntLevel);
  modport cond (input inSel, output cntPulse, output cntLevel);
endinterface

// ==== core/if_input_cond.sv ====
// pin synchronisers, input select and fm prescaler
`timescale 1ns/1ps
module if_input_cond
  import if_counter_pkg::*;
(
  input  wire logic mclk,           // system clock
  input  wire logic rst,            // synchronous reset, active high
  input  wire logic ce,             // clock enable
  input  wire logic fmIfInputPin,   // fm if pin, asynchronous
  input  wire logic amIfInputPin,   // am if pin, asynchronous
  if_sel_intf.cond  link            // to counter core
);
  logic [2:0] fmSync_r;
  logic [2:0] amSync_r;
  logic       fmLvl_r;
  logic       amLvl_r;
  logic [1:0] preDiv_r;
  logic       cntPulse_r;
  logic       cntLevel_r;
  logic       fmRise;
  logic       amRise;
  logic       selFm;
  logic       selAm;

  // three flip-flop synchronisers
  always_ff @(posedge mclk)
    if (rst)
    begin
      fmSync_r <= 3'h0;
      amSync_r <= 3'h0;
    end
    else if (ce)
    begin
      fmSync_r <= {fmSync_r[1:0], fmIfInputPin};
      amSync_r <= {amSync_r[1:0], amIfInputPin};
    end

  // a rising edge counts once the second and third stages agree
  assign fmRise = (fmSync_r[1] == fmSync_r[2]) && fmSync_r[2] && !fmLvl_r;
  assign amRise = (amSync_r[1] == amSync_r[2]) && amSync_r[2] && !amLvl_r;
  assign selFm  = link.inSel == 2'h2;
  assign selAm  = link.inSel == 2'h3;

  // filtered pin levels
  always_ff @(posedge mclk)
    if (rst)
    begin
      fmLvl_r <= 1'b0;
      amLvl_r <= 1'b0;
    end
    else if (ce)
    begin
      if (fmSync_r[1] == fmSync_r[2])
        fmLvl_r <= fmSync_r[2];
      if (amSync_r[1] == amSync_r[2])
        amLvl_r <= amSync_r[2];
    end

  // divide-by-four prescaler, only runs while fm is selected
  always_ff @(posedge mclk)
    if (rst)
      preDiv_r <= 2'h0;
    else if (ce)
    begin
      if (!selFm)
        preDiv_r <= 2'h0;
      else if (fmRise)
        preDiv_r <= preDiv_r + 2'h1;
    end

  // count pulse and level of the selected signal, prescaled when fm is selected, taken directly when am
  always_ff @(posedge mclk)
    if (rst)
    begin
      cntPulse_r <= 1'b0;
      cntLevel_r <= 1'b0;
    end
    else if (ce)
    begin
      cntPulse_r <= (selFm && fmRise && preDiv_r == 2'h1) || (selAm && amRise);
      cntLevel_r <= (selFm && preDiv_r[1]) || (selAm && amLvl_r);
    end

  assign link.cntPulse = cntPulse_r;
  assign link.cntLevel = cntLevel_r;

  property p_no_pulse_disabled;
    @(posedge mclk) disable iff (rst)
    (ce && !link.inSel[1]) |=> !cntPulse_r;
  endproperty
  a_no_pulse_disabled: assert property (p_no_pulse_disabled)
    else $error("count pulse while inputs disabled");
endmodule

// ==== core/if_frequency_counter.sv ====
// intermediate-frequency counter core with its register port
`timescale 1ns/1ps
module if_frequency_counter
  import if_counter_pkg::*;
#(
  parameter int TICK_CYCLES_P = if_counter_pkg::TICK_CYCLES  // 1 kHz tick period in mclk
)
(
  input  wire logic       mclk,          // system clock, 25 MHz
  input  wire logic       rst,           // synchronous reset, active high
  input  wire logic       ce,            // clock enable, when low freezes all state except under reset
  input  wire logic [7:0] sfrAddr,       // register address
  input  wire logic       sfrWr,         // register write strobe
  input  wire logic       sfrRd,         // register read strobe
  input  wire logic [7:0] sfrWdata,      // register write data
  input  wire logic       irqAck,        // interrupt routine entered
  input  wire logic       fmIfInputPin,  // fm if input pin
  input  wire logic       amIfInputPin,  // am if input pin
  output logic      [7:0] rdData,        // register read data
  output logic            irqReq,        // counter interrupt request pulse
  output logic            gateOpen       // gate is open
);
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_OPEN} gate_state_t;

  gate_state_t        state_r;
  gate_state_t        state_nxt;
  logic               judge_r;
  logic               start_r;
  logic [2:0]         gateSel_r;
  logic [1:0]         inSel_r;
  logic [CNT_W-1:0]   count_r;
  logic               ovf_r;
  logic [TICK_W-1:0]  tickCnt_r;
  logic               tick_r;
  logic [7:0]         msCnt_r;
  logic [7:0]         rdData_r;
  logic               irqReq_r;
  logic               gateOpen_r;
  logic               modeWr;
  logic               modeRd;
  logic               startWr;
  logic               stopWr;
  logic               clearWr;
  logic               softMode;
  logic               openEvt;
  logic               endEvt;
  logic               inc;
  logic               ovfHit;

  if_sel_intf link ();

  if_input_cond u_cond (
    .mclk         (mclk),
    .rst          (rst),
    .ce           (ce),
    .fmIfInputPin (fmIfInputPin),
    .amIfInputPin (amIfInputPin),
    .link         (link.cond)
  );

  // gate length in 1 kHz ticks, zero for soft or reserved codes
  function automatic logic [7:0] gateLen(input logic [2:0] code);
    logic [7:0] len;
    len = 8'h00;
    case (code)
      GT_8MS:   len = LEN_8MS;
      GT_32MS:  len = LEN_32MS;
      GT_128MS: len = LEN_128MS;
      GT_1MS:   len = LEN_1MS;
      GT_4MS:   len = LEN_4MS;
      default:  len = 8'h00;
    endcase
    return len;
  endfunction

  // register strobes; result registers ignore writes
  assign modeWr   = ce && sfrWr && sfrAddr == FREQ_COUNTER_MODE_REG_ADDR;
  assign modeRd   = ce && sfrRd && sfrAddr == FREQ_COUNTER_MODE_REG_ADDR;
  assign startWr  = modeWr && sfrWdata[COUNT_START_STOP_BIT];
  assign stopWr   = modeWr && !sfrWdata[COUNT_START_STOP_BIT];
  assign clearWr  = modeWr && sfrWdata[COUNT_CLEAR_BIT];
  assign softMode = gateSel_r == GT_SOFT;
  assign link.inSel = inSel_r;

  // mode fields; start drops by itself when a timed gate closes
  always_ff @(posedge mclk)
    if (rst)
    begin
      start_r   <= MODE_RESET[COUNT_START_STOP_BIT];
      gateSel_r <= MODE_RESET[GATE_TIME_SEL_LSB +: 3];
      inSel_r   <= MODE_RESET[1:0];
    end
    else if (ce)
    begin
      if (modeWr)
      begin
        start_r   <= sfrWdata[COUNT_START_STOP_BIT];
        gateSel_r <= sfrWdata[GATE_TIME_SEL_LSB +: 3];
        inSel_r   <= sfrWdata[INPUT_SEL_AM_FM_BIT +: 2];
      end
      else if (endEvt)
        start_r <= 1'b0;
    end

  // free-running 1 kHz tick divided from the system clock
  always_ff @(posedge mclk)
    if (rst)
    begin
      tickCnt_r <= '0;
      tick_r    <= 1'b0;
    end
    else if (ce)
    begin
      if (tickCnt_r == TICK_W'(TICK_CYCLES_P - 1))
        tickCnt_r <= '0;
      else
        tickCnt_r <= tickCnt_r + 1'b1;
      tick_r <= tickCnt_r == TICK_W'(TICK_CYCLES_P - 1);
    end

  // gate sequencing
  always_comb
  begin
    state_nxt = state_r;
    openEvt   = 1'b0;
    endEvt    = 1'b0;
    case (state_r)
      ST_IDLE:
        if (startWr && sfrWdata[GATE_TIME_SEL_LSB +: 3] == GT_SOFT)
        begin
          state_nxt = ST_OPEN;
          openEvt   = 1'b1;
        end
        else if (startWr && gateLen(sfrWdata[GATE_TIME_SEL_LSB +: 3]) != 8'h00)
          state_nxt = ST_WAIT;
      ST_WAIT:
        if (stopWr)
          state_nxt = ST_IDLE;
        else if (ce && tick_r)
        begin
          state_nxt = ST_OPEN;
          openEvt   = 1'b1;
        end
      ST_OPEN:
        if (stopWr)
          state_nxt = ST_IDLE;
        else if (ce && !softMode && tick_r && msCnt_r == gateLen(gateSel_r) - 8'h01)
        begin
          state_nxt = ST_IDLE;
          endEvt    = 1'b1;
        end
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk)
    if (rst)
      state_r <= ST_IDLE;
    else if (ce)
      state_r <= state_nxt;

  // milliseconds elapsed inside the gate
  always_ff @(posedge mclk)
    if (rst)
      msCnt_r <= 8'h00;
    else if (ce)
    begin
      if (openEvt)
        msCnt_r <= 8'h00;
      else if (state_r == ST_OPEN && tick_r)
        msCnt_r <= msCnt_r + 8'h01;
    end

  // one count per count pulse (each am rising edge, every fourth fm edge), plus one if high as the gate opens
  assign inc = (state_r == ST_OPEN && link.cntPulse) || (openEvt && link.cntLevel);

  // an increment at full scale raises overflow, even beside a clear
  assign ovfHit = inc && count_r == OVF_VALUE;

  // result counter and sticky overflow
  always_ff @(posedge mclk)
    if (rst)
    begin
      count_r <= CNT_RESET;
      ovf_r   <= 1'b0;
    end
    else if (ce)
    begin
      if (clearWr)
      begin
        count_r <= CNT_RESET;
        ovf_r   <= ovfHit;
      end
      else if (inc)
      begin
        if (count_r == OVF_VALUE)
          ovf_r <= 1'b1;
        else
          count_r <= count_r + 1'b1;
      end
    end

  // judge flag: end of timed count sets it, and the set wins
  always_ff @(posedge mclk)
    if (rst)
      judge_r <= MODE_RESET[COUNT_DONE_JUDGE_FLAG_BIT];
    else if (ce)
    begin
      if (endEvt)
        judge_r <= 1'b1;
      else if ((modeRd || irqAck) && !softMode)
        judge_r <= 1'b0;
    end

  // interrupt request and gate status outputs
  always_ff @(posedge mclk)
    if (rst)
    begin
      irqReq_r   <= 1'b0;
      gateOpen_r <= 1'b0;
    end
    else if (ce)
    begin
      irqReq_r   <= endEvt;
      gateOpen_r <= state_nxt == ST_OPEN;
    end

  // registered read data
  always_ff @(posedge mclk)
    if (rst)
      rdData_r <= UNMAPPED_READ;
    else if (ce && sfrRd)
    begin
      if (sfrAddr == FREQ_COUNTER_MODE_REG_ADDR)
        rdData_r <= {judge_r, start_r, 1'b0, gateSel_r, inSel_r};
      else if (sfrAddr == FREQ_COUNT_HIGH_REG_ADDR)
        rdData_r <= {HIGH_RSVD_VALUE, ovf_r, count_r[18:16]};
      else if (sfrAddr == FREQ_COUNT_MID_REG_ADDR)
        rdData_r <= count_r[15:8];
      else if (sfrAddr == FREQ_COUNT_LOW_REG_ADDR)
        rdData_r <= count_r[7:0];
      else
        rdData_r <= UNMAPPED_READ;
    end

  assign rdData   = rdData_r;
  assign irqReq   = irqReq_r;
  assign gateOpen = gateOpen_r;

  property p_reset_zero;
    @(posedge mclk) disable iff (rst)
    $past(rst) |-> count_r == CNT_RESET && !ovf_r;
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("counter not zero after reset");

  property p_clear;
    @(posedge mclk) disable iff (rst)
    clearWr |=> count_r == CNT_RESET && ovf_r == $past(ovfHit);
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear write did not clear result");

  property p_hold_closed;
    @(posedge mclk) disable iff (rst)
    (state_r != ST_OPEN && !openEvt && !clearWr) |=> $stable(count_r);
  endproperty
  a_hold_closed: assert property (p_hold_closed)
    else $error("count changed with gate closed");

  property p_ovf_sticky;
    @(posedge mclk) disable iff (rst)
    (ovf_r && !clearWr) |=> ovf_r;
  endproperty
  a_ovf_sticky: assert property (p_ovf_sticky)
    else $error("overflow flag dropped without clear");

  property p_judge_end;
    @(posedge mclk) disable iff (rst)
    endEvt |=> judge_r && irqReq_r && !gateOpen_r ##1 !irqReq_r;
  endproperty
  a_judge_end: assert property (p_judge_end)
    else $error("gate end did not set judge and pulse irq");

  property p_judge_read;
    @(posedge mclk) disable iff (rst)
    (modeRd && !softMode && !endEvt) |=> !judge_r;
  endproperty
  a_judge_read: assert property (p_judge_read)
    else $error("judge not cleared by mode read");

  property p_stop;
    @(posedge mclk) disable iff (rst)
    stopWr |=> state_r == ST_IDLE && !gateOpen_r;
  endproperty
  a_stop: assert property (p_stop)
    else $error("stop write did not close gate");

  property p_high_rsvd;
    @(posedge mclk) disable iff (rst)
    (ce && sfrRd && sfrAddr == FREQ_COUNT_HIGH_REG_ADDR) |=>
      rdData_r[7:4] == HIGH_RSVD_VALUE && rdData_r[3] == $past(ovf_r);
  endproperty
  a_high_rsvd: assert property (p_high_rsvd)
    else $error("high register layout wrong");

  property p_open_on_tick;
    @(posedge mclk) disable iff (rst)
    (ce && state_r == ST_WAIT && !stopWr && !tick_r) |=> state_r == ST_WAIT;
  endproperty
  a_open_on_tick: assert property (p_open_on_tick)
    else $error("gate opened without a tick");
endmodule

// ==== testbench/if_signal_source.sv ====
// square-wave model of the tuner if stages driving both counter pins
`timescale 1ns/1ps
module if_signal_source
(
  input  wire logic       mclk,        // system clock, paces the model
  input  wire logic       enable,      // source running
  input  wire logic [7:0] halfCycles,  // clocks per half period, two or more
  output logic            fmPin,       // fm if output
  output logic            amPin        // am if output
);
  logic [7:0] phaseCnt_r;  // clocks spent in this half period
  logic       wave_r;      // square wave level

  // toggle each half period; edges stay at least two clocks apart
  always_ff @(posedge mclk)
  begin
    if (!enable)
    begin
      phaseCnt_r <= 8'h00;
      wave_r     <= 1'b0;
    end
    else if (phaseCnt_r + 8'h01 >= halfCycles)
    begin
      phaseCnt_r <= 8'h00;
      wave_r     <= ~wave_r;
    end
    else
      phaseCnt_r <= phaseCnt_r + 8'h01;
  end

  // both pins carry the wave; a stopped source rests low
  assign fmPin = wave_r;
  assign amPin = wave_r;
endmodule

// ==== testbench/if_frequency_counter_tb.sv ====
// self-checking bench for the if frequency counter
`timescale 1ns/1ps
module if_frequency_counter_tb;
  import if_counter_pkg::*;
  localparam int TICK = 20;  // shortened 1 kHz tick
  localparam int HALF = 4;   // source half period in clocks
  logic       mclk, rst, ce, sfrWr, sfrRd, irqAck, srcOn;
  logic       fmPin, amPin, irqReq, gateOpen;
  logic [7:0] sfrAddr, sfrWdata, rdData;
  int         nErrors, samplesChecked, irqCount;

  if_frequency_counter #(.TICK_CYCLES_P(TICK)) u_if_frequency_counter (
    .mclk(mclk), .rst(rst), .ce(ce), .sfrAddr(sfrAddr), .sfrWr(sfrWr),
    .sfrRd(sfrRd), .sfrWdata(sfrWdata), .irqAck(irqAck), .fmIfInputPin(fmPin),
    .amIfInputPin(amPin), .rdData(rdData), .irqReq(irqReq), .gateOpen(gateOpen));
  if_signal_source u_if_signal_source (
    .mclk(mclk), .enable(srcOn), .halfCycles(8'(HALF)), .fmPin(fmPin), .amPin(amPin));

  // clock at 25 MHz
  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // count request pulses seen by the clock
  always @(posedge mclk)
    if (irqReq === 1'b1) irqCount++;

  task automatic stopTest;
    $display("errors %0d checks %0d", nErrors, samplesChecked);
    if (nErrors == 0 && samplesChecked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [18:0] got, input logic [18:0] lo, input logic [18:0] hi);
    logic ok;
    ok = (got >= lo) && (got <= hi);
    samplesChecked++;
    if (ok !== 1'b1)
    begin
      nErrors++;
      $display("[ERR] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask

  // register write and read, driven on the falling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    sfrAddr = a; sfrWdata = d; sfrWr = 1'b1;
    @(negedge mclk);
    sfrWr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk);
    sfrAddr = a; sfrRd = 1'b1;
    @(negedge mclk);
    sfrRd = 1'b0;
    d = rdData;
  endtask

  // result read in three bytes, high byte layout checked on the way
  task automatic readCount(output logic [18:0] cnt);
    logic [7:0] h, m, l;
    rd(FREQ_COUNT_HIGH_REG_ADDR, h);
    rd(FREQ_COUNT_MID_REG_ADDR, m);
    rd(FREQ_COUNT_LOW_REG_ADDR, l);
    chk(19'(h & 8'hF8), 19'h000F0, 19'h000F0);
    cnt = {h[2:0], m, l};
  endtask

  // expected count window for a measured gate length
  task automatic chkCount(input logic [18:0] cnt, input logic [1:0] sel, input int len);
    int base;
    base = !sel[1] ? 0 : (sel[0] ? len / (2 * HALF) : len / (8 * HALF));
    chk(cnt, 19'(base > 0 ? base - 1 : 0), 19'(sel[1] ? base + 2 : 0));
  endtask

  // select, clear, start; then time the gate and read the result
  task automatic runGate(input logic [2:0] gt, input logic [1:0] sel, output int len,
                         output logic [18:0] cnt);
    int i;
    wr(FREQ_COUNTER_MODE_REG_ADDR, {3'b000, gt, sel});
    wr(FREQ_COUNTER_MODE_REG_ADDR, {3'b001, gt, sel});
    wr(FREQ_COUNTER_MODE_REG_ADDR, {3'b010, gt, sel});
    irqCount = 0;
    len = 0;
    for (i = 0; i < TICK + 4 && gateOpen !== 1'b1; i++) @(negedge mclk);
    while (gateOpen === 1'b1 && len < 3000)
    begin
      @(negedge mclk);
      len++;
    end
    chk(19'(irqReq), 19'h1, 19'h1);
    readCount(cnt);
  endtask

  task automatic testReset;
    logic [7:0] d;
    rd(FREQ_COUNTER_MODE_REG_ADDR, d);
    chk(19'(d), 19'(MODE_RESET), 19'(MODE_RESET));
    rd(FREQ_COUNT_HIGH_REG_ADDR, d);
    chk(19'(d), 19'h000F0, 19'h000F0);
    rd(FREQ_COUNT_MID_REG_ADDR, d);
    chk(19'(d), 19'h0, 19'h0);
    rd(FREQ_COUNT_LOW_REG_ADDR, d);
    chk(19'(d), 19'h0, 19'h0);
    rd(8'hF3, d);
    chk(19'(d), 19'(UNMAPPED_READ), 19'(UNMAPPED_READ));
  endtask

  // every timed code, fm and am alternately, judge polled by mode reads
  task automatic testTimed;
    logic [2:0]  gts [5] = '{GT_1MS, GT_4MS, GT_8MS, GT_32MS, GT_128MS};
    logic [7:0]  ms [5]  = '{LEN_1MS, LEN_4MS, LEN_8MS, LEN_32MS, LEN_128MS};
    logic [1:0]  sel;
    logic [18:0] cnt;
    logic [7:0]  d;
    int          len;
    for (int i = 0; i < 5; i++)
    begin
      sel = (i % 2 == 1) ? 2'b10 : 2'b11;
      runGate(gts[i], sel, len, cnt);
      chk(19'(len), 19'(int'(ms[i]) * TICK), 19'(int'(ms[i]) * TICK));
      chkCount(cnt, sel, len);
      rd(FREQ_COUNTER_MODE_REG_ADDR, d);
      chk(19'(d), 19'({3'b100, gts[i], sel}), 19'({3'b100, gts[i], sel}));
      rd(FREQ_COUNTER_MODE_REG_ADDR, d);
      chk(19'(d), 19'({3'b000, gts[i], sel}), 19'({3'b000, gts[i], sel}));
    end
  endtask

  // judge cleared by interrupt entry; read-only results; clear bit
  task automatic testAckAndRegs;
    logic [18:0] cnt;
    logic [7:0]  d, v;
    int          len;
    runGate(GT_4MS, 2'b11, len, cnt);
    @(negedge mclk);
    irqAck = 1'b1;
    @(negedge mclk);
    irqAck = 1'b0;
    rd(FREQ_COUNTER_MODE_REG_ADDR, d);
    chk(19'(d), 19'({3'b000, GT_4MS, 2'b11}), 19'({3'b000, GT_4MS, 2'b11}));
    rd(FREQ_COUNT_LOW_REG_ADDR, v);
    wr(FREQ_COUNT_LOW_REG_ADDR, ~v);
    wr(FREQ_COUNT_HIGH_REG_ADDR, 8'h07);
    readCount(cnt);
    chk(cnt, 19'(v), 19'(v));
    wr(FREQ_COUNTER_MODE_REG_ADDR, {3'b001, GT_4MS, 2'b11});
    readCount(cnt);
    chk(cnt, CNT_RESET, CNT_RESET);
    runGate(GT_4MS, 2'b00, len, cnt);
    chk(cnt, CNT_RESET, CNT_RESET);
  endtask

  // software gate counts while start is high, no completion events
  task automatic testSoft;
    logic [18:0] cnt;
    logic [7:0]  d;
    int          len;
    wr(FREQ_COUNTER_MODE_REG_ADDR, {3'b001, GT_SOFT, 2'b11});
    wr(FREQ_COUNTER_MODE_REG_ADDR, {3'b010, GT_SOFT, 2'b11});
    irqCount = 0;
    len = 0;
    repeat (60)
    begin
      @(negedge mclk);
      if (gateOpen === 1'b1) len++;
    end
    wr(FREQ_COUNTER_MODE_REG_ADDR, {3'b000, GT_SOFT, 2'b11});
    repeat (3) @(negedge mclk);
    chk(19'(len), 19'd58, 19'd60);
    chk(19'(gateOpen), 19'h0, 19'h0);
    chk(19'(irqCount), 19'h0, 19'h0);
    readCount(cnt);
    chkCount(cnt, 2'b11, len);
    // judge left set by the previous timed gate survives soft-mode reads
    rd(FREQ_COUNTER_MODE_REG_ADDR, d);
    chk(19'(d[7]), 19'h1, 19'h1);
    rd(FREQ_COUNTER_MODE_REG_ADDR, d);
    chk(19'(d[7]), 19'h1, 19'h1);
    wr(FREQ_COUNTER_MODE_REG_ADDR, {3'b010, 3'b110, 2'b11});
    repeat (TICK * 2) @(negedge mclk);
    chk(19'(gateOpen), 19'h0, 19'h0);
    wr(FREQ_COUNTER_MODE_REG_ADDR, 8'h00);
  endtask

  // clock enable low ignores a start; a mid-run reset clears a live result
  task automatic testFreezeAndReset;
    logic [18:0] cnt;
    int          len;
    runGate(GT_4MS, 2'b11, len, cnt);
    chkCount(cnt, 2'b11, len);
    @(negedge mclk);
    ce = 1'b0;
    wr(FREQ_COUNTER_MODE_REG_ADDR, {3'b010, GT_1MS, 2'b11});
    repeat (TICK * 2) @(negedge mclk);
    chk(19'(gateOpen), 19'h0, 19'h0);
    rst = 1'b1;
    @(negedge mclk);
    rst = 1'b0;
    ce  = 1'b1;
    testReset();
  endtask

  // watchdog on the whole run
  initial
  begin
    repeat (20000) @(posedge mclk);
    nErrors++;
    stopTest();
  end

  initial
  begin
    nErrors = 0; samplesChecked = 0; irqCount = 0;
    rst = 1'b1; ce = 1'b1; sfrWr = 1'b0; sfrRd = 1'b0; irqAck = 1'b0;
    sfrAddr = 8'h00; sfrWdata = 8'h00; srcOn = 1'b0;
    repeat (4) @(negedge mclk);
    rst = 1'b0;
    srcOn = 1'b1;
    testReset();
    testTimed();
    testAckAndRegs();
    testSoft();
    testFreezeAndReset();
    stopTest();
  end
endmodule
